// ===== src/dfta_chan_adjust.sv
// Purpose: raise decision and below-threshold flag for one channel
// Assumes: limits, operating point, threshold and long tick come from core registers; temp and format from core inputs
// Notes:   combinational; the core applies the step
module dfta_chan_adjust
   import dfta_pkg::*;
(
   dfta_chan_if.adj ch
);

   logic in_long;
   logic cold;
   logic under_high;
   logic under_op;
   logic temp_above;

   // ==========================================================================
   // guard terms; all but in_long are strict compares in the active format
   assign in_long    = ch.long_tick;                                       // [R01] [R15]
   assign cold       = temp_less(ch.temp, ch.low_lim, ch.off64);           // [R01] [R05]
   assign under_high = temp_less(ch.thr, ch.high_lim, ch.off64);           // [R02]
   assign under_op   = temp_less(ch.thr, ch.op_point, ch.off64);           // [R03]
   assign temp_above = temp_less(ch.thr, ch.temp, ch.off64);               // [R04]

   // below threshold: fan to off/minimum and adjustment suspended
   assign ch.below = temp_less(ch.temp, ch.thr, ch.off64);                 // [R07]

   // one step of raise only when every guard holds
   assign ch.raise = ch.dyn_en & in_long & cold & under_high & under_op
                     & temp_above & ~ch.below;                             // [R04] [R07]

endmodule : dfta_chan_adjust

// ===== src/dfta_chan_if.sv
// Purpose: bundle between the core and one channel adjuster
// Assumes: core owns all state, the adjuster is pure decision logic
// Notes:   one instance per temperature channel
interface dfta_chan_if;
   logic [7:0] temp;
   logic [7:0] low_lim;
   logic [7:0] high_lim;
   logic [7:0] op_point;
   logic [7:0] thr;
   logic       dyn_en;
   logic       long_tick;
   logic       off64;
   logic       raise;
   logic       below;

   modport core (output temp, output low_lim, output high_lim, output op_point,
                 output thr, output dyn_en, output long_tick, output off64,
                 input raise, input below);
   modport adj  (input temp, input low_lim, input high_lim, input op_point,
                 input thr, input dyn_en, input long_tick, input off64,
                 output raise, output below);
endinterface : dfta_chan_if

// ===== src/dfta_core.sv
// Purpose: fan start threshold raise and operating point capture, three channels
// Assumes: temperature inputs hold the last completed conversion; monitor_tick is
//          one mclk pulse per monitoring cycle; register port is synchronous
// Notes:   reads return the value of the addressed register one cycle later
//
// Operation
// R01: raise the threshold only in the long cycle while temperature is below low limit
// R02: never raise the threshold to or past the high limit; the code raises it until it equals the high limit
// R03: raise only while the threshold is below the operating point
// R04: raise only while temperature is above the threshold
// R05: once temperature is back above the low limit, hold the threshold
// R06: threshold floor is -127 two's complement or -64 offset-64
// R07: below the threshold, fan off or minimum and no adjustment
// R08: capture bit 2 copies remote 1 temperature to its operating point on alert
// R09: capture bit 3 copies local temperature to its operating point on alert
// R10: capture bit 4 copies remote 2 temperature to its operating point on alert
// R11: bit 5 enables remote 1 dynamic threshold adjustment
// R12: bit 6 enables local dynamic threshold adjustment
// R13: bit 7 enables remote 2 dynamic threshold adjustment
// R14: the processor asserts overheating by pulling the thermal pin low
// R15: long cycle happens once every two short cycles of n monitoring cycles
// R16: high and low limits are 8-bit values of one degree
// R17: synchronise the thermal pin and capture on a detected assertion
module dfta_core
   import dfta_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             monitor_tick,
   input  wire logic             temp_format_offset64,
   input  wire logic [7:0]       remote1_temp,
   input  wire logic [7:0]       local_temp,
   input  wire logic [7:0]       remote2_temp,
   input  wire logic             thermal_alert_pin_n,
   input  wire logic [7:0]       reg_addr,
   input  wire logic             reg_wr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata,
   output logic      [2:0][7:0]  fan_start_threshold,
   output logic      [2:0][7:0]  operating_point,
   output logic      [2:0]       fan_min_speed,
   output logic                  long_cycle_pulse
);

   // ==========================================================================
   // state
   typedef struct packed {
      logic [7:0]           ctrl1;
      logic [2:0][7:0]      op;
      logic [2:0][7:0]      low;
      logic [2:0][7:0]      high;
      logic [2:0][7:0]      thr;
      logic [MON_CNT_W-1:0] mon_cnt;
      logic                 long_tick;
      logic [2:0]           below;
      logic [2:0]           captured;
      logic [7:0]           rdata;
   } dfta_core_state_t;

   dfta_core_state_t state_reg;
   dfta_core_state_t state_next;

   logic [2:0][7:0] temp_now;
   logic [2:0]      raise;
   logic [2:0]      below_now;
   logic            thermal_alert_pin_pulse;
   logic            off64;

   // channel order matches the register tables
   assign temp_now = {remote2_temp, local_temp, remote1_temp};
   assign off64    = temp_format_offset64;

   // ==========================================================================
   // thermal pin front end
   dfta_thermal_sync u_sync (
      .mclk                (mclk),
      .resetn              (resetn),
      .thermal_alert_pin_n (thermal_alert_pin_n),
      .assert_pulse        (thermal_alert_pin_pulse)
   );

   // ==========================================================================
   // per-channel decision logic
   dfta_chan_if chan_if [NUM_CHAN] ();

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
         assign chan_if[gi].temp      = temp_now[gi];
         assign chan_if[gi].low_lim   = state_reg.low[gi];
         assign chan_if[gi].high_lim  = state_reg.high[gi];
         assign chan_if[gi].op_point  = state_reg.op[gi];
         assign chan_if[gi].thr       = state_reg.thr[gi];
         assign chan_if[gi].dyn_en    = state_reg.ctrl1[DYN_BIT_BASE+gi];  // [R11] [R12] [R13]
         assign chan_if[gi].long_tick = state_reg.long_tick;
         assign chan_if[gi].off64     = off64;
         assign raise[gi]             = chan_if[gi].raise;
         assign below_now[gi]         = chan_if[gi].below;

         dfta_chan_adjust u_adj (
            .ch (chan_if[gi])
         );
      end
   endgenerate

   // clamp a threshold to the floor of the active format
   function automatic logic [7:0] clamp_floor(input logic [7:0] v, input logic fmt);
      logic [7:0] res;
      res = temp_less(v, thr_floor(fmt), fmt) ? thr_floor(fmt) : v;
      return res;
   endfunction : clamp_floor

   // read mux over the whole map; unmapped reads give zero
   function automatic logic [7:0] read_mux(input dfta_core_state_t s,
                                           input logic [7:0]       a);
      logic [7:0] res;
      res = 8'h00;
      if (a == ADDR_CTRL1) begin
         res = s.ctrl1;
      end
      if (a == ADDR_STAT) begin
         res = {2'h0, s.captured, s.below};
      end
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (a == ADDR_OP[c]) begin
            res = s.op[c];
         end
         if (a == ADDR_LOW[c]) begin
            res = s.low[c];
         end
         if (a == ADDR_HIGH[c]) begin
            res = s.high[c];
         end
         if (a == ADDR_THR[c]) begin
            res = s.thr[c];
         end
      end
      return res;
   endfunction : read_mux

   // ==========================================================================
   // next state
   always_comb begin
      state_next           = state_reg;
      state_next.long_tick = 1'b0;

      // monitoring cycle counter; long cycle is 2n monitoring cycles
      if (monitor_tick) begin
         if (state_reg.mon_cnt == LONG_CYCLE_LAST) begin
            state_next.mon_cnt   = '0;
            state_next.long_tick = 1'b1;                                  // [R15]
         end else begin
            state_next.mon_cnt = state_reg.mon_cnt + MON_CNT_W'(1);
         end
      end

      // below-threshold status drives the fan minimum request
      state_next.below = below_now;                                       // [R07]

      // threshold step first, so a software write in the same cycle wins
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (raise[c]) begin
            state_next.thr[c] = state_reg.thr[c] + 8'h01;                 // [R01] [R02] [R03]
         end
         // no raise leaves the value where it is
      end                                                                 // [R05]

      // software writes
      if (reg_wr) begin
         if (reg_addr == ADDR_CTRL1) begin
            state_next.ctrl1 = reg_wdata;
         end
         if (reg_addr == ADDR_STAT) begin
            // write-one-to-clear of capture flags, set below wins
            state_next.captured = state_reg.captured & ~reg_wdata[5:3];
         end
         for (int c = 0; c < NUM_CHAN; c++) begin
            if (reg_addr == ADDR_OP[c]) begin
               state_next.op[c] = reg_wdata;
            end
            if (reg_addr == ADDR_LOW[c]) begin
               state_next.low[c] = reg_wdata;                             // [R16]
            end
            if (reg_addr == ADDR_HIGH[c]) begin
               state_next.high[c] = reg_wdata;                            // [R16]
            end
            if (reg_addr == ADDR_THR[c]) begin
               state_next.thr[c] = clamp_floor(reg_wdata, off64);         // [R06]
            end
         end
      end

      // floor holds even if the format flips under a stored value
      for (int c = 0; c < NUM_CHAN; c++) begin
         state_next.thr[c] = clamp_floor(state_next.thr[c], off64);       // [R06]
      end

      // capture on alert overrides a same-cycle software write
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (thermal_alert_pin_pulse && state_reg.ctrl1[CAPTURE_BIT_BASE+c]) begin
            state_next.op[c]       = temp_now[c];                         // [R08] [R09] [R10]
            state_next.captured[c] = 1'b1;                                // [R17]
         end
      end

      // read data registered from the current state
      state_next.rdata = read_mux(state_reg, reg_addr);
   end

   // ==========================================================================
   // state register, synchronous active-low reset
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_reg.ctrl1     <= CTRL1_RESET;
         state_reg.op        <= {3{OP_RESET}};
         state_reg.low       <= {3{LOW_RESET}};
         state_reg.high      <= {3{HIGH_RESET}};
         state_reg.thr       <= {3{THR_RESET}};
         state_reg.mon_cnt   <= '0;
         state_reg.long_tick <= 1'b0;
         state_reg.below     <= 3'h0;
         state_reg.captured  <= 3'h0;
         state_reg.rdata     <= 8'h00;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================================
   // outputs, all from flops
   assign reg_rdata           = state_reg.rdata;
   assign fan_start_threshold = state_reg.thr;
   assign operating_point     = state_reg.op;
   assign fan_min_speed       = state_reg.below;                         // [R07]
   assign long_cycle_pulse    = state_reg.long_tick;

endmodule : dfta_core

// ===== src/dfta_pkg.sv
// Purpose: constants, register map and shared decode for the fan start threshold adjuster
// Assumes: channel 0 = remote 1, channel 1 = local, channel 2 = remote 2
// Notes:   temperatures are 8-bit codes, two's complement or offset-64 by a mode input
package dfta_pkg;

   // ==========================================================================
   // sizes
   localparam int NUM_CHAN  = 3;
   localparam int TEMP_W    = 8;
   localparam int MON_CNT_W = 11;

   // ==========================================================================
   // register offsets, one byte each, index = channel
   localparam logic [7:0]             ADDR_CTRL1 = 8'h36;
   localparam logic [2:0][7:0]        ADDR_OP    = {8'h35, 8'h34, 8'h33};
   localparam logic [2:0][7:0]        ADDR_LOW   = {8'h52, 8'h50, 8'h4e};
   localparam logic [2:0][7:0]        ADDR_HIGH  = {8'h53, 8'h51, 8'h4f};
   localparam logic [2:0][7:0]        ADDR_THR   = {8'h72, 8'h71, 8'h70};
   localparam logic [7:0]             ADDR_STAT  = 8'h73;

   // ==========================================================================
   // field positions in the control register
   localparam int CAPTURE_BIT_BASE = 2;     // bits 4:2, capture on thermal assertion
   localparam int DYN_BIT_BASE     = 5;     // bits 7:5, dynamic threshold enable

   // ==========================================================================
   // reset values
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [7:0] OP_RESET    = 8'ha4;
   localparam logic [7:0] LOW_RESET   = 8'h01;
   localparam logic [7:0] HIGH_RESET  = 8'h7f;
   localparam logic [7:0] THR_RESET   = 8'h5a;

   // ==========================================================================
   // threshold floors per format
   localparam logic [7:0] FLOOR_TWOS  = 8'h81;   // -127 degrees
   localparam logic [7:0] FLOOR_OFF64 = 8'h00;   // -64 degrees

   // ==========================================================================
   // timing: short cycle in monitoring cycles, long cycle is twice that
   localparam int                   SHORT_CYCLE_MONITORS = 8;
   localparam logic [MON_CNT_W-1:0] LONG_CYCLE_LAST      =
      MON_CNT_W'(2 * SHORT_CYCLE_MONITORS - 1);

   // strict less-than in the active temperature format
   function automatic logic temp_less(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       off64);
      logic res;
      res = off64 ? (a < b) : ($signed(a) < $signed(b));
      return res;
   endfunction : temp_less

   // lowest code the threshold may take
   function automatic logic [7:0] thr_floor(input logic off64);
      logic [7:0] res;
      res = off64 ? FLOOR_OFF64 : FLOOR_TWOS;
      return res;
   endfunction : thr_floor

endpackage : dfta_pkg

// ===== src/dfta_thermal_sync.sv
// Purpose: bring the active-low thermal pin into the clock domain, flag assertions
// Assumes: pin idles high; an assertion is a high-to-low transition
// Notes:   pulse comes three edges after the pin falls
module dfta_thermal_sync
   import dfta_pkg::*;
(
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic thermal_alert_pin_n,
   output logic      assert_pulse
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic pulse;
   } dfta_sync_state_t;

   dfta_sync_state_t state_reg;
   dfta_sync_state_t state_next;

   // ==========================================================================
   // synchroniser and fall detector; only sync feeds the detector
   always_comb begin
      state_next       = state_reg;
      state_next.meta  = thermal_alert_pin_n;
      state_next.sync  = state_reg.meta;
      state_next.prev  = state_reg.sync;
      state_next.pulse = state_reg.prev & ~state_reg.sync;   // low level asserts [R14] [R17]
   end

   // idle-high reset so release does not fake an assertion
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_reg <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, pulse: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign assert_pulse = state_reg.pulse;

endmodule : dfta_thermal_sync

// ===== verif/dfta_core_chk.sv
// Purpose: port-level checks of the fan start threshold adjuster
// Assumes: temperatures held steady around long cycles and alerts
// Notes:   limits and control are shadowed from the register port
module dfta_core_chk
   import dfta_pkg::*;
(
   input wire logic            mclk,
   input wire logic            resetn,
   input wire logic            monitor_tick,
   input wire logic            temp_format_offset64,
   input wire logic [7:0]      remote1_temp,
   input wire logic [7:0]      local_temp,
   input wire logic [7:0]      remote2_temp,
   input wire logic            thermal_alert_pin_n,
   input wire logic [7:0]      reg_addr,
   input wire logic            reg_wr,
   input wire logic [7:0]      reg_wdata,
   input wire logic [7:0]      reg_rdata,
   input wire logic [2:0][7:0] fan_start_threshold,
   input wire logic [2:0][7:0] operating_point,
   input wire logic [2:0]      fan_min_speed,
   input wire logic            long_cycle_pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0]      ctl_reg;
   logic [2:0][7:0] lo_reg;
   logic [2:0][7:0] hi_reg;
   logic [4:0]      tick_reg;
   logic [2:0][7:0] t;
   logic [2:0]      ok;
   logic [2:0]      bl;

   function automatic logic lt(input logic [7:0] a, input logic [7:0] b, input logic m);
      return m ? (a < b) : ($signed(a) < $signed(b));
   endfunction : lt

   // ==========================================================================
   // shadow state: limits are internal, so mirror the writes
   assign t = {remote2_temp, local_temp, remote1_temp};
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ctl_reg  <= CTRL1_RESET;
         lo_reg   <= {3{LOW_RESET}};
         hi_reg   <= {3{HIGH_RESET}};
         tick_reg <= 5'h00;
      end else begin
         if (reg_wr && reg_addr == ADDR_CTRL1) ctl_reg <= reg_wdata;
         for (int c = 0; c < 3; c++) begin
            if (reg_wr && reg_addr == ADDR_LOW[c]) lo_reg[c] <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_HIGH[c]) hi_reg[c] <= reg_wdata;
         end
         tick_reg <= long_cycle_pulse ? 5'(monitor_tick) : tick_reg + 5'(monitor_tick);
      end
   end

   // raise permission and below-threshold flag, in the active format
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         bl[c] = lt(t[c], fan_start_threshold[c], temp_format_offset64);
         ok[c] = ctl_reg[DYN_BIT_BASE + c] && lt(t[c], lo_reg[c], temp_format_offset64)
               && lt(fan_start_threshold[c], hi_reg[c], temp_format_offset64)
               && lt(fan_start_threshold[c], operating_point[c], temp_format_offset64)
               && !bl[c] && fan_start_threshold[c] != t[c];
      end
   end

   // ==========================================================================
   // assertions
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // pin idle for three samples, then seen low
   sequence alert_s;
      thermal_alert_pin_n [*3] ##1 !thermal_alert_pin_n;
   endsequence

   pulse_one_a: assert property (
      long_cycle_pulse |=> !long_cycle_pulse) else $error("long cycle pulse too long");
   long_period_a: assert property (
      long_cycle_pulse |-> tick_reg == 5'h10) else $error("long cycle not after 16 ticks");
   ctrl_read_a: assert property (
      (reg_wr && reg_addr == ADDR_CTRL1) ##1 (!reg_wr && reg_addr == ADDR_CTRL1)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("control readback wrong");

   for (genvar c = 0; c < 3; c++) begin : g_ch
      raise_step_a: assert property (
         long_cycle_pulse && ok[c] && !reg_wr |=> fan_start_threshold[c] ==
         $past(fan_start_threshold[c]) + 8'h01) else $error("threshold did not rise");
      raise_gate_a: assert property (
         $past(resetn) && !$past(reg_wr) && temp_format_offset64 == $past(temp_format_offset64, 2)
         && fan_start_threshold[c] == $past(fan_start_threshold[c]) + 8'h01
         |-> $past(long_cycle_pulse && ok[c])) else $error("threshold rose without cause");
      floor_a: assert property (
         temp_format_offset64 == $past(temp_format_offset64, 2) |-> !lt(fan_start_threshold[c],
         temp_format_offset64 ? FLOOR_OFF64 : FLOOR_TWOS, temp_format_offset64))
         else $error("threshold below floor");
      min_speed_a: assert property (
         $past(resetn) |-> fan_min_speed[c] == $past(bl[c])) else $error("fan minimum flag wrong");
      capture_a: assert property (
         alert_s ##0 (ctl_reg[CAPTURE_BIT_BASE + c] && !reg_wr)
         |-> ##[2:5] operating_point[c] == t[c]) else $error("operating point not captured");
      capture_off_a: assert property (
         alert_s ##0 (!ctl_reg[CAPTURE_BIT_BASE + c] && !reg_wr)
         |=> $stable(operating_point[c]) [*5]) else $error("operating point changed");
   end
endmodule : dfta_core_chk

bind dfta_core dfta_core_chk dfta_core_chk_i (
   .mclk(mclk), .resetn(resetn), .monitor_tick(monitor_tick),
   .temp_format_offset64(temp_format_offset64), .remote1_temp(remote1_temp),
   .local_temp(local_temp), .remote2_temp(remote2_temp),
   .thermal_alert_pin_n(thermal_alert_pin_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fan_start_threshold(fan_start_threshold),
   .operating_point(operating_point), .fan_min_speed(fan_min_speed),
   .long_cycle_pulse(long_cycle_pulse));

// ===== verif/dfta_hot_model.sv
// Purpose: processor hot output driving the active-low thermal pin
// Assumes: pin has a pull-up, so it reads high whenever released
// Notes:   go starts one assertion after lag cycles, held hold_len+1 cycles
module dfta_hot_model (
   input  wire logic       mclk,
   input  wire logic       go,
   input  wire logic [3:0] lag,
   input  wire logic [3:0] hold_len,
   output logic            pin_n,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      pin_n = 1'b1;
      busy  = 1'b0;
   end
   // overheating pulls the pin low; lag lets it answer promptly or slowly
   always @(posedge mclk) begin
      if (go) begin
         #1 busy = 1'b1;
         repeat (lag) begin
            @(posedge mclk);
            #1;
         end
         pin_n = 1'b0;
         repeat (hold_len + 1) @(posedge mclk);
         #1 pin_n = 1'b1;
         busy = 1'b0;
      end
   end
endmodule : dfta_hot_model

// ===== verif/tb.sv
// Purpose: self-checking bench for the fan start threshold adjuster
// Assumes: registers reached only through the core's register port
// Notes:   model keeps thresholds and operating points per channel
module tb
   import dfta_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic            mclk = 1'b0, resetn = 1'b0, tick = 1'b0, fmt = 1'b0, wr = 1'b0, go = 1'b0;
   logic [7:0]      addr = 8'h00, wdata = 8'h00, rdata, ctl;
   logic [2:0][7:0] temp = '0, thr_o, op_o;
   logic [2:0]      slow, bm;
   logic            pin_n, busy, pulse;
   logic [3:0]      lag = 4'h0, hold_len = 4'h0;
   logic [7:0]      m_thr [3], m_op [3], lo [3], hi [3], op [3];
   int              seed = 13, fail_count = 0, n_compared = 0, cycles = 0;

   always #50 mclk = ~mclk;
   dfta_core dfta_core_i (.mclk(mclk), .resetn(resetn), .monitor_tick(tick),
      .temp_format_offset64(fmt), .remote1_temp(temp[0]), .local_temp(temp[1]),
      .remote2_temp(temp[2]), .thermal_alert_pin_n(pin_n), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rdata(rdata), .fan_start_threshold(thr_o),
      .operating_point(op_o), .fan_min_speed(slow), .long_cycle_pulse(pulse));
   dfta_hot_model dfta_hot_model_i (.mclk(mclk), .go(go), .lag(lag), .hold_len(hold_len),
      .pin_n(pin_n), .busy(busy));

   // ==========================================================================
   // helpers
   function automatic bit lt(input logic [7:0] a, input logic [7:0] b);
      return fmt ? a < b : $signed(a) < $signed(b);
   endfunction : lt
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // idle cycle after each write so the strobe is never re-raised in one step
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      cyc(2);
      chk(rdata, exp);
   endtask : rd_reg
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   // one long cycle with limits placed near the threshold, so raises happen often
   task automatic raise_round();
      fmt = 1'($random(seed));
      ctl = 8'($random(seed));
      wr_reg(ADDR_CTRL1, ctl);
      rd_reg(ADDR_CTRL1, ctl);
      for (int c = 0; c < 3; c++) begin
         m_thr[c] = 8'($random(seed));
         temp[c] = m_thr[c] - 8'h01 + 8'({$random(seed)} % 4);
         lo[c] = temp[c] + 8'({$random(seed)} % 2);
         hi[c] = m_thr[c] + 8'({$random(seed)} % 4);
         op[c] = m_thr[c] + 8'({$random(seed)} % 4);
         wr_reg(ADDR_THR[c], m_thr[c]);
         wr_reg(ADDR_LOW[c], lo[c]);
         wr_reg(ADDR_HIGH[c], hi[c]);
         wr_reg(ADDR_OP[c], op[c]);
         rd_reg(ADDR_LOW[c], lo[c]);
         if (lt(m_thr[c], fmt ? FLOOR_OFF64 : FLOOR_TWOS)) m_thr[c] = fmt ? FLOOR_OFF64 : FLOOR_TWOS;
      end
      repeat (16) begin
         tick = 1'b1;
         cyc(1);
         tick = 1'b0;
         cyc(1);
      end
      cyc(3);
      for (int c = 0; c < 3; c++) begin
         if (ctl[DYN_BIT_BASE + c] && lt(temp[c], lo[c]) && lt(m_thr[c], hi[c])
             && lt(m_thr[c], op[c]) && lt(m_thr[c], temp[c])) m_thr[c]++;
         chk(thr_o[c], m_thr[c]);
         chk({7'h00, slow[c]}, {7'h00, lt(temp[c], m_thr[c])});
      end
   endtask : raise_round

   // ==========================================================================
   // main sequence
   initial begin
      cyc(20);
      resetn = 1'b1;
      for (int c = 0; c < 3; c++) begin
         rd_reg(ADDR_OP[c], 8'ha4);
         rd_reg(ADDR_LOW[c], 8'h01);
         rd_reg(ADDR_HIGH[c], 8'h7f);
         rd_reg(ADDR_THR[c], 8'h5a);
      end
      rd_reg(ADDR_CTRL1, 8'h00);
      rd_reg(8'h00, 8'h00);
      // floor: clamped in two's complement, kept in offset-64, clamped again on return
      wr_reg(ADDR_THR[0], 8'h80);
      rd_reg(ADDR_THR[0], 8'h81);
      fmt = 1'b1;
      wr_reg(ADDR_THR[0], 8'h80);
      rd_reg(ADDR_THR[0], 8'h80);
      fmt = 1'b0;
      cyc(2);
      chk(thr_o[0], 8'h81);
      repeat (16) raise_round();
      // every capture mask, alert answered promptly and slowly
      for (int k = 0; k < 8; k++) begin
         wr_reg(ADDR_CTRL1, 8'(k << CAPTURE_BIT_BASE));
         for (int c = 0; c < 3; c++) begin
            m_op[c] = 8'($random(seed));
            wr_reg(ADDR_OP[c], m_op[c]);
            temp[c] = 8'($random(seed));
            if (k[c]) m_op[c] = temp[c];
         end
         lag = 4'(k % 4);
         hold_len = 4'(k);
         go = 1'b1;
         cyc(1);
         go = 1'b0;
         cyc(1);
         for (int i = 0; i < 40 && busy; i++) cyc(1);
         chk({7'h00, busy}, 8'h00);
         cyc(6);
         for (int c = 0; c < 3; c++) chk(op_o[c], m_op[c]);
      end
      // status: every channel has captured by now; clear remote 1 and remote 2 flags
      for (int c = 0; c < 3; c++) bm[c] = lt(temp[c], m_thr[c]);
      rd_reg(ADDR_STAT, {2'h0, 3'h7, bm});
      wr_reg(ADDR_STAT, 8'h28);
      rd_reg(ADDR_STAT, {2'h0, 3'h2, bm});
      print_verdict();
   end

   // hang guard, well above the roughly 1340 cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
endmodule : tb
